/* File: design/hpi_port.sv */
// Eight-bit host port: register access, event flags, control-cell send and receive.
// Assumes host pins and bus clocks are asynchronous; cell-side strobes are on clk_sys.
//
// Operation
// - Strap low: separate low strobes, high interrupt, high ready, low means wait.
// - Strap high: read/write select line, low interrupt, low acknowledge, inactive waits.
// - Twelve latched flags and the cell-ready flag at 05H and 08H, each gated by its enable.
// - Reading a status register clears it except flags whose cause persists.
// - Sent control cell sets positive or negative acknowledge flag, bits 6 and 7.
// - Received cell parity value differing from computed value sets parity flag.
// - Frame pulse missing over four frames, or write clock lost, sets frame loss.
// - Missing read clock and missing write clock each set their own flag.
// - Header check field differing from computed value sets header error flag.
// - A fifth cell arriving at the full receive queue sets overflow flag.
// - ATM and back-to-back modes flag missing or early start-of-cell.
// - PHY mode flags missing or early start-of-cell, and any cell while off.
// - Valid-signal mode flags receive-valid dropping inside a cell.
// - Grant not arriving within programmed frame count sets grant timeout.
// - Outlet overflow on single limit 123 or split queue limits.
// - Cell sent after pending data; then done flag set and go cleared.
// - Receive queue head shown in window; presence sets cell-ready flag.
// - Host release write pops head and clears release bit; ready clears once the queue is empty.
// - Control-cell send and receive ignore the inlet acceptance bit.
`timescale 1ns/10ps
`default_nettype none

module hpi_port #(
    parameter int TX_BYTES = 56,
    parameter int RX_BYTES = 52,
    parameter int RX_CELLS = 4,
    parameter int INLET_CELL_BYTES = 53
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic bus_style_strap,
    input wire logic host_sel_n,
    input wire logic host_rd_n,
    input wire logic host_wr_n,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_data_i,
    output logic [7:0] host_data_o,
    output logic host_data_oe_n,
    output logic host_ready_o,
    output logic host_ready_oe_n,
    output logic host_irq_o,
    input wire logic bus_read_clock,
    input wire logic bus_write_clock,
    input wire logic bus_frame_pulse,
    input wire logic cell_check_stb,
    input wire logic [7:0] bip_carried,
    input wire logic [7:0] bip_computed,
    input wire logic hdr_check_stb,
    input wire logic [3:0] crc_carried,
    input wire logic [3:0] crc_computed,
    input wire logic grant_req,
    input wire logic grant_in,
    input wire logic outlet_push,
    input wire hpi_pkg::hpi_queue_t outlet_queue,
    input wire logic [6:0] outlet_count,
    input wire logic inlet_byte_stb,
    input wire logic inlet_sof,
    input wire logic inlet_cell_avail,
    input wire logic inlet_enable_n,
    input wire logic phy_emul_select_n,
    input wire logic valid_mode,
    input wire logic link_rx_valid,
    input wire logic ctl_rx_valid,
    input wire logic [7:0] ctl_rx_byte,
    input wire logic ctl_rx_last,
    output logic ctl_tx_valid,
    output logic [7:0] ctl_tx_byte,
    output logic ctl_tx_last,
    input wire logic ctl_tx_ready,
    input wire logic ctl_tx_ack_stb,
    input wire logic ctl_tx_nack_stb
);
    import hpi_pkg::*;

    localparam int LOSS_CYC = (`HPI_CLK_LOSS_NS + `HPI_CLK_PERIOD_NS - 1) / `HPI_CLK_PERIOD_NS;
    localparam int LW = $clog2(LOSS_CYC + 1);
    localparam logic [LW-1:0] LOSS_LIM = LOSS_CYC[LW-1:0];

    if (TX_BYTES < 2 || TX_BYTES > 63 || INLET_CELL_BYTES < 2 || INLET_CELL_BYTES > 63)
    begin : g_chk
        $error("hpi_port: unsupported buffer or cell length");
    end

    typedef struct packed {
        logic strap;
        logic sel_n;
        logic rd_n;
        logic wr_n;
        logic [7:0] addr;
        logic [7:0] data;
        logic rclk;
        logic wclk;
        logic fp;
    } hpi_pins_t;

    typedef struct packed {
        hpi_pins_t s1;
        hpi_pins_t s2;
        logic rclk_q;
        logic wclk_q;
        hpi_acc_t acc;
        logic [7:0] dout;
        logic dout_oe_n;
        logic rdy;
        logic rdy_oe_n;
        logic irq;
        logic [7:0] sa;
        logic [7:0] ea;
        logic [7:0] sb;
        logic [7:0] eb;
        logic [7:0] ctl;
        logic [7:0] cfg;
        logic [7:0] gwait;
        logic [7:0] cbr_queue_length;
        logic [TX_BYTES-1:0][7:0] txb;
        logic tx_busy;
        logic tx_v;
        logic tx_last;
        logic [5:0] tx_idx;
        logic [7:0] tx_byte;
        logic [LW-1:0] rc_cnt;
        logic [LW-1:0] wc_cnt;
        logic [3:0] cyc;
        logic [2:0] miss;
        logic [7:0] gcnt;
        logic [5:0] in_cnt;
    } hpi_state_t;

    hpi_state_t r_ff;
    hpi_state_t nxt_r;
    hpi_rxq_if rxq ();

    function automatic logic in_rng(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    hpi_rx_queue #(
        .CELLS(RX_CELLS),
        .BYTES(RX_BYTES)
    ) u_rxq (
        .clk_sys(clk_sys),
        .rst(rst),
        .q(rxq.queue)
    );

    // ============================================================
    // Receive queue hookup, independent of inlet acceptance
    assign rxq.in_valid = ctl_rx_valid;
    assign rxq.in_byte = ctl_rx_byte;
    assign rxq.in_last = ctl_rx_last;
    assign rxq.win_idx = 6'(r_ff.s2.addr - `HPI_OFF_RXWIN_LO);

    logic rd_req;
    logic wr_req;
    logic rd_now;
    logic wr_now;
    logic rclk_edge;
    logic wclk_rise;
    logic frame_tick;
    logic rc_loss;
    logic wc_loss;
    logic frm_loss;
    logic sof_err;
    logic out_ovf;
    logic no_grant;
    logic tx_done;
    logic phy;
    logic xfer;
    logic [6:0] q_lim;
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic [7:0] hold_a;
    logic [7:0] hold_b;
    logic [7:0] rdata;
    logic [7:0] a;
    logic [7:0] d;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.s1 = '{strap: bus_style_strap, sel_n: host_sel_n, rd_n: host_rd_n,
                     wr_n: host_wr_n, addr: host_addr, data: host_data_i,
                     rclk: bus_read_clock, wclk: bus_write_clock, fp: bus_frame_pulse};
        nxt_r.s2 = r_ff.s1;
        nxt_r.rclk_q = r_ff.s2.rclk;
        nxt_r.wclk_q = r_ff.s2.wclk;
        a = r_ff.s2.addr;
        d = r_ff.s2.data;
        rxq.release_pulse = 1'b0;

        // ============================================================
        // Host strobe decoding per strap
        if (r_ff.s2.strap) begin
            rd_req = !r_ff.s2.sel_n && r_ff.s2.rd_n;
            wr_req = !r_ff.s2.sel_n && !r_ff.s2.rd_n;
        end else begin
            rd_req = !r_ff.s2.sel_n && !r_ff.s2.rd_n;
            wr_req = !r_ff.s2.sel_n && !r_ff.s2.wr_n;
        end
        rd_now = (r_ff.acc == HPI_EXEC) && rd_req;
        wr_now = (r_ff.acc == HPI_EXEC) && wr_req;

        // ============================================================
        // Bus clock supervision and frame tracking
        rclk_edge = r_ff.s2.rclk ^ r_ff.rclk_q;
        wclk_rise = r_ff.s2.wclk && !r_ff.wclk_q;
        nxt_r.rc_cnt = rclk_edge ? '0 : (r_ff.rc_cnt == LOSS_LIM) ? r_ff.rc_cnt
                       : r_ff.rc_cnt + LW'(1);
        nxt_r.wc_cnt = (r_ff.s2.wclk ^ r_ff.wclk_q) ? '0 : (r_ff.wc_cnt == LOSS_LIM)
                       ? r_ff.wc_cnt : r_ff.wc_cnt + LW'(1);
        rc_loss = (r_ff.rc_cnt == LOSS_LIM);
        wc_loss = (r_ff.wc_cnt == LOSS_LIM);
        frame_tick = wclk_rise && (r_ff.s2.fp || r_ff.cyc == `HPI_FRAME_CYC);
        if (wclk_rise) begin
            nxt_r.cyc = r_ff.s2.fp ? 4'h0 : r_ff.cyc + 4'h1;
            if (r_ff.s2.fp) begin
                nxt_r.miss = 3'h0;
            end else if (r_ff.cyc == `HPI_FRAME_CYC && r_ff.miss <= `HPI_FRAME_MISS_MAX) begin
                nxt_r.miss = r_ff.miss + 3'h1;
            end
        end
        frm_loss = (r_ff.miss > `HPI_FRAME_MISS_MAX) || wc_loss;

        // ============================================================
        // Grant wait in frames
        no_grant = 1'b0;
        if (!grant_req || grant_in) begin
            nxt_r.gcnt = 8'h00;
        end else if (frame_tick && r_ff.gcnt != 8'hff) begin
            nxt_r.gcnt = r_ff.gcnt + 8'h01;
            no_grant = (r_ff.gcnt == r_ff.gwait);
        end

        // ============================================================
        // Outlet overflow limits
        if (!r_ff.cfg[`HPI_BIT_SPLIT_Q]) begin
            q_lim = `HPI_LIM_SINGLE;
        end else begin
            case (outlet_queue)
                HPI_Q_CTL: q_lim = `HPI_LIM_CTL;
                HPI_Q_CBR: q_lim = r_ff.cbr_queue_length[6:0];
                HPI_Q_VBR: q_lim = `HPI_LIM_VBR_BASE - r_ff.cbr_queue_length[6:0];
                default: q_lim = `HPI_LIM_ABR;
            endcase
        end
        out_ovf = outlet_push && (outlet_count >= q_lim);

        // ============================================================
        // Inlet start-of-cell checking
        phy = !phy_emul_select_n;
        xfer = valid_mode ? link_rx_valid : phy ? !inlet_enable_n : inlet_cell_avail;
        sof_err = 1'b0;
        if (inlet_byte_stb) begin
            if (valid_mode && !link_rx_valid && r_ff.in_cnt != 6'd0) begin
                sof_err = 1'b1;
                nxt_r.in_cnt = 6'd0;
            end else if (xfer) begin
                if ((r_ff.in_cnt == 6'd0) != inlet_sof) begin
                    sof_err = 1'b1;
                end
                if (phy && !r_ff.cfg[`HPI_BIT_ACCEPT_ON] && r_ff.in_cnt == 6'd0) begin
                    sof_err = 1'b1;
                end
                nxt_r.in_cnt = (r_ff.in_cnt == 6'(INLET_CELL_BYTES - 1)) ? 6'd0
                               : r_ff.in_cnt + 6'd1;
            end
        end

        // ============================================================
        // Control-cell transmit
        tx_done = 1'b0;
        if (r_ff.tx_v && ctl_tx_ready) begin
            if (r_ff.tx_last) begin
                nxt_r.tx_v = 1'b0;
                nxt_r.tx_last = 1'b0;
                nxt_r.tx_busy = 1'b0;
                tx_done = 1'b1;
            end else begin
                nxt_r.tx_idx = r_ff.tx_idx + 6'd1;
                nxt_r.tx_byte = r_ff.txb[r_ff.tx_idx + 6'd1];
                nxt_r.tx_last = (r_ff.tx_idx + 6'd1 == 6'(TX_BYTES - 1));
            end
        end

        // ============================================================
        // Register read data
        if (a == `HPI_OFF_STAT_A) begin
            rdata = r_ff.sa;
        end else if (a == `HPI_OFF_EN_A) begin
            rdata = r_ff.ea;
        end else if (a == `HPI_OFF_STAT_B) begin
            rdata = r_ff.sb;
        end else if (a == `HPI_OFF_EN_B) begin
            rdata = r_ff.eb;
        end else if (a == `HPI_OFF_CTL) begin
            rdata = {r_ff.ctl[7:2], r_ff.tx_busy, 1'b0};
        end else if (a == `HPI_OFF_CFG) begin
            rdata = r_ff.cfg;
        end else if (a == `HPI_OFF_GWAIT) begin
            rdata = r_ff.gwait;
        end else if (a == `HPI_OFF_CBR_QUEUE_LENGTH) begin
            rdata = r_ff.cbr_queue_length;
        end else if (in_rng(a, `HPI_OFF_RXWIN_LO, `HPI_OFF_RXWIN_HI)) begin
            rdata = rxq.win_byte;
        end else if (in_rng(a, `HPI_OFF_TXBUF_LO, `HPI_OFF_TXBUF_HI)) begin
            rdata = r_ff.txb[6'(a - `HPI_OFF_TXBUF_LO)];
        end else begin
            rdata = 8'h00;
        end

        // ============================================================
        // Register writes
        if (wr_now) begin
            if (a == `HPI_OFF_EN_A) begin
                nxt_r.ea = d;
            end else if (a == `HPI_OFF_EN_B) begin
                nxt_r.eb = d;
            end else if (a == `HPI_OFF_CTL) begin
                nxt_r.ctl = {d[7:2], 2'b00};
                rxq.release_pulse = d[`HPI_BIT_RX_RELEASE];
                if (d[`HPI_BIT_TX_GO] && !r_ff.tx_busy) begin
                    nxt_r.tx_busy = 1'b1;
                    nxt_r.tx_v = 1'b1;
                    nxt_r.tx_idx = 6'd0;
                    nxt_r.tx_byte = r_ff.txb[0];
                    nxt_r.tx_last = 1'b0;
                end
            end else if (a == `HPI_OFF_CFG) begin
                nxt_r.cfg = d;
            end else if (a == `HPI_OFF_GWAIT) begin
                nxt_r.gwait = d;
            end else if (a == `HPI_OFF_CBR_QUEUE_LENGTH) begin
                nxt_r.cbr_queue_length = d;
            end else if (in_rng(a, `HPI_OFF_TXBUF_LO, `HPI_OFF_TXBUF_HI)) begin
                nxt_r.txb[6'(a - `HPI_OFF_TXBUF_LO)] = d;
            end
        end

        // ============================================================
        // Event flags: set wins over read clear, persisting causes stay
        set_a = '0;
        set_a[`HPI_BIT_TX_NACK] = ctl_tx_nack_stb;
        set_a[`HPI_BIT_TX_ACK] = ctl_tx_ack_stb;
        set_a[`HPI_BIT_BIP] = cell_check_stb && (bip_carried != bip_computed);
        hold_a = '0;
        hold_a[`HPI_BIT_FRAME_LOSS] = frm_loss;
        hold_a[`HPI_BIT_RCLK_LOSS] = rc_loss;
        hold_a[`HPI_BIT_WCLK_LOSS] = wc_loss;
        set_b = '0;
        set_b[`HPI_BIT_CRC] = hdr_check_stb && (crc_carried != crc_computed);
        set_b[`HPI_BIT_RX_OVF] = rxq.ovf;
        set_b[`HPI_BIT_SOF_ERR] = sof_err;
        set_b[`HPI_BIT_TX_DONE] = tx_done;
        set_b[`HPI_BIT_NO_GRANT] = no_grant;
        set_b[`HPI_BIT_OUT_OVF] = out_ovf;
        hold_b = '0;
        hold_b[`HPI_BIT_RX_READY] = rxq.avail;
        nxt_r.sa = ((rd_now && a == `HPI_OFF_STAT_A) ? 8'h00 : r_ff.sa) | set_a | hold_a;
        nxt_r.sb = ((rd_now && a == `HPI_OFF_STAT_B) ? 8'h00 : r_ff.sb) | set_b | hold_b;
        nxt_r.sb[`HPI_BIT_RX_READY] = rxq.avail;

        // ============================================================
        // Interrupt pin, masked regardless of bus clocks
        nxt_r.irq = |((r_ff.sa & r_ff.ea) | (r_ff.sb & r_ff.eb)) ^ r_ff.s2.strap;

        // ============================================================
        // Host access sequencer and handshake pins
        case (r_ff.acc)
            HPI_IDLE: begin
                if (rd_req || wr_req) begin
                    nxt_r.acc = HPI_EXEC;
                end
            end
            HPI_EXEC: begin
                nxt_r.acc = HPI_HOLD;
                nxt_r.dout = rdata;
                nxt_r.dout_oe_n = !rd_req;
            end
            default: begin
                if (!rd_req && !wr_req) begin
                    nxt_r.acc = HPI_IDLE;
                    nxt_r.dout_oe_n = 1'b1;
                end
            end
        endcase
        if (r_ff.s2.strap) begin
            nxt_r.rdy = 1'b0;
            nxt_r.rdy_oe_n = !(nxt_r.acc == HPI_HOLD);
        end else begin
            nxt_r.rdy = !((rd_req || wr_req) && nxt_r.acc != HPI_HOLD);
            nxt_r.rdy_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r_ff <= '0;
            r_ff.ctl <= `HPI_RST_CTL;
            r_ff.dout_oe_n <= 1'b1;
            r_ff.rdy_oe_n <= 1'b1;
            r_ff.s1.sel_n <= 1'b1;
            r_ff.s2.sel_n <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign host_data_o = r_ff.dout;
    assign host_data_oe_n = r_ff.dout_oe_n;
    assign host_ready_o = r_ff.rdy;
    assign host_ready_oe_n = r_ff.rdy_oe_n;
    assign host_irq_o = r_ff.irq;
    assign ctl_tx_valid = r_ff.tx_v;
    assign ctl_tx_byte = r_ff.tx_byte;
    assign ctl_tx_last = r_ff.tx_last;
endmodule

`default_nettype wire

/* File: design/hpi_regs.svh */
// Register offsets, field positions, reset values and timing of the host port.
// Assumes inclusion by bare name from the package, whose macros the port module uses.
`ifndef HPI_REGS_SVH
`define HPI_REGS_SVH

// ============================================================
// Register offsets
`define HPI_OFF_STAT_A 8'h05
`define HPI_OFF_EN_A 8'h06
`define HPI_OFF_STAT_B 8'h08
`define HPI_OFF_EN_B 8'h09
`define HPI_OFF_CTL 8'h0a
`define HPI_OFF_CFG 8'h0c
`define HPI_OFF_GWAIT 8'h0f
`define HPI_OFF_CBR_QUEUE_LENGTH 8'h10
`define HPI_OFF_RXWIN_LO 8'h60
`define HPI_OFF_RXWIN_HI 8'h93
`define HPI_OFF_TXBUF_LO 8'ha0
`define HPI_OFF_TXBUF_HI 8'hd7

// ============================================================
// Status A fields
`define HPI_BIT_TX_NACK 7
`define HPI_BIT_TX_ACK 6
`define HPI_BIT_BIP 5
`define HPI_BIT_FRAME_LOSS 4
`define HPI_BIT_RCLK_LOSS 3
`define HPI_BIT_WCLK_LOSS 2
// Status B fields
`define HPI_BIT_CRC 7
`define HPI_BIT_RX_OVF 6
`define HPI_BIT_RX_READY 5
`define HPI_BIT_SOF_ERR 4
`define HPI_BIT_TX_DONE 3
`define HPI_BIT_NO_GRANT 2
`define HPI_BIT_OUT_OVF 0
// Control and configuration fields
`define HPI_BIT_TX_GO 1
`define HPI_BIT_RX_RELEASE 0
`define HPI_BIT_ACCEPT_ON 7
`define HPI_BIT_SPLIT_Q 2

// ============================================================
// Reset values
`define HPI_RST_CTL 8'h40
`define HPI_RST_OTHER 8'h00

// ============================================================
// Queue limits and timing
`define HPI_LIM_SINGLE 7'h7b
`define HPI_LIM_ABR 7'h20
`define HPI_LIM_VBR_BASE 7'h59
`define HPI_LIM_CTL 7'h02
`define HPI_FRAME_CYC 4'hf
`define HPI_FRAME_MISS_MAX 3'h4
`define HPI_CLK_PERIOD_NS 25
`define HPI_CLK_LOSS_NS 1000

`endif

/* File: design/hpi_pkg.sv */
// Types shared by the host port and its receive queue.
// Assumes hpi_regs.svh is reachable on the include path.
package hpi_pkg;
    `include "hpi_regs.svh"

    // ============================================================
    // Host access sequencer, Gray coded
    typedef enum logic [1:0] {
        HPI_IDLE = 2'b00,
        HPI_EXEC = 2'b01,
        HPI_HOLD = 2'b11
    } hpi_acc_t;

    // ============================================================
    // Outlet queue select
    typedef enum logic [1:0] {
        HPI_Q_CTL = 2'b00,
        HPI_Q_CBR = 2'b01,
        HPI_Q_VBR = 2'b10,
        HPI_Q_ABR = 2'b11
    } hpi_queue_t;
endpackage

/* File: design/hpi_rxq_if.sv */
// Link between the host port and the control-cell receive queue.
// Assumes both ends run on clk_sys.
`timescale 1ns/10ps
`default_nettype none

interface hpi_rxq_if;
    logic in_valid;
    logic [7:0] in_byte;
    logic in_last;
    logic [5:0] win_idx;
    logic [7:0] win_byte;
    logic release_pulse;
    logic avail;
    logic ovf;

    modport port (
        output in_valid, in_byte, in_last, win_idx, release_pulse,
        input win_byte, avail, ovf
    );
    modport queue (
        input in_valid, in_byte, in_last, win_idx, release_pulse,
        output win_byte, avail, ovf
    );
endinterface

`default_nettype wire

/* File: design/hpi_rx_queue.sv */
// Four-cell control receive FIFO whose head cell is the host read window.
// Assumes cell bytes arrive on clk_sys, one per in_valid, in_last on the final byte.
`timescale 1ns/10ps
`default_nettype none

module hpi_rx_queue #(
    parameter int CELLS = 4,
    parameter int BYTES = 52
) (
    input wire logic clk_sys,
    input wire logic rst,
    hpi_rxq_if.queue q
);
    import hpi_pkg::*;

    localparam int PW = $clog2(CELLS);
    localparam logic [PW:0] FULL = CELLS[PW:0];

    if (CELLS < 2 || (1 << PW) != CELLS || BYTES < 2 || BYTES > 63) begin : g_chk
        $error("hpi_rx_queue: unsupported CELLS or BYTES");
    end

    typedef struct packed {
        logic [CELLS-1:0][BYTES-1:0][7:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
        logic [5:0] bi;
        logic drop;
        logic ovf;
    } hpi_rxq_state_t;

    hpi_rxq_state_t r_ff;
    hpi_rxq_state_t nxt_r;
    logic drop_now;
    logic push;
    logic pop;

    // ============================================================
    // Fill, overflow and release
    always_comb begin
        nxt_r = r_ff;
        nxt_r.ovf = 1'b0;
        push = 1'b0;
        drop_now = (r_ff.bi == 6'd0) ? (r_ff.cnt == FULL) : r_ff.drop;
        pop = q.release_pulse && (r_ff.cnt != '0);
        if (q.in_valid) begin
            nxt_r.drop = drop_now;
            if (!drop_now && r_ff.bi < BYTES[5:0]) begin
                nxt_r.mem[r_ff.wp][r_ff.bi] = q.in_byte;
            end
            nxt_r.bi = r_ff.bi + 6'd1;
            if (q.in_last) begin
                nxt_r.bi = 6'd0;
                if (drop_now) begin
                    nxt_r.ovf = 1'b1;
                end else begin
                    push = 1'b1;
                    nxt_r.wp = r_ff.wp + {{(PW-1){1'b0}}, 1'b1};
                end
            end
        end
        if (pop) begin
            nxt_r.rp = r_ff.rp + {{(PW-1){1'b0}}, 1'b1};
        end
        nxt_r.cnt = r_ff.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ============================================================
    // Head cell as read window
    always_comb begin
        q.win_byte = 8'h00;
        if (q.win_idx < BYTES[5:0]) begin
            q.win_byte = r_ff.mem[r_ff.rp][q.win_idx];
        end
    end
    assign q.avail = (r_ff.cnt != '0);
    assign q.ovf = r_ff.ovf;
endmodule

`default_nettype wire

/* File: test/hpi_port_properties.sv */
// Pin checks of the host port, strap low.
// Assumes bind by name from the bench top.
`timescale 1ns/10ps
`default_nettype none
module hpi_port_properties (
    input wire logic clk_sys, rst, bus_style_strap, host_sel_n, host_rd_n, host_wr_n,
    input wire logic host_data_oe_n, host_ready_o, host_ready_oe_n, host_irq_o,
    input wire logic ctl_tx_valid, ctl_tx_last, ctl_tx_ready,
    input wire logic [7:0] ctl_tx_byte
);
    // ======
    // Bus, ready, interrupt and control-cell send checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_idle;
        (host_sel_n && host_rd_n && host_wr_n) [*4];
    endsequence
    a_bus_release: assert property (s_idle |=> host_data_oe_n)
        else $error("bus held");
    a_write_quiet: assert property (!host_wr_n |-> host_data_oe_n)
        else $error("bus driven");
    a_read_drive: assert property ($fell(host_rd_n) |-> ##[2:5] !host_data_oe_n)
        else $error("no drive");
    a_wait_state: assert property ($fell(host_wr_n) |-> ##[2:4] !host_ready_o)
        else $error("no wait");
    a_ready_driven: assert property (!bus_style_strap [*4] |-> !host_ready_oe_n)
        else $error("ready floats");
    a_irq_reset: assert property ($fell(rst) |-> !host_irq_o)
        else $error("irq set");
    a_tx_hold: assert property (ctl_tx_valid && !ctl_tx_ready |=> $stable(ctl_tx_byte))
        else $error("byte moved");
    a_tx_end: assert property (ctl_tx_ready && ctl_tx_last |=> !ctl_tx_valid)
        else $error("ran on");
endmodule
`default_nettype wire

/* File: test/hpi_host_model.sv */
// Host master with separate strobes.
// Assumes strap low.
`timescale 1ns/10ps
`default_nettype none
module hpi_host_model (
    input wire logic clk, rdy,
    input wire logic [7:0] din,
    output logic sel_n, rd_n, wr_n,
    output logic [7:0] addr, dout
);
    // ======
    // One access
    initial {sel_n, rd_n, wr_n, addr, dout} = {3'h7, 16'h0000};
    task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        int n;
        n = 0;
        {sel_n, rd_n, wr_n, addr, dout} <= {1'b0, w, !w, a, d};
        do @(posedge clk); while (rdy && ++n < 9);
        do @(posedge clk); while (!rdy && ++n < 30);
        q = din;
        {sel_n, rd_n, wr_n} <= 3'h7;
        repeat (5) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: test/hpi_port_tb.sv */
// Bench of the host port.
// Assumes design and model compiled first.
`timescale 1ns/10ps
`default_nettype none
module hpi_port_tb;
    import hpi_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, bus_style_strap = 1'b0, bus_read_clock = 1'b0;
    logic grant_req = 1'b0, grant_in = 1'b0, outlet_push = 1'b0, inlet_byte_stb = 1'b0;
    logic inlet_sof = 1'b0, inlet_cell_avail = 1'b0, inlet_enable_n = 1'b1, valid_mode = 1'b0;
    logic phy_emul_select_n = 1'b1, link_rx_valid = 1'b0, ctl_tx_ready = 1'b0;
    logic ctl_rx_valid = 1'b0, ctl_rx_last = 1'b0, host_sel_n, host_rd_n, host_wr_n;
    logic host_data_oe_n, host_ready_o, host_ready_oe_n, host_irq_o, ctl_tx_valid, ctl_tx_last;
    logic [3:0] crc_carried = 4'h0, crc_computed = 4'h1, stb = 4'h0, fcnt = 4'h0;
    logic [6:0] outlet_count = 7'h00;
    logic [7:0] bip_carried = 8'h00, bip_computed = 8'h01, ctl_rx_byte = 8'h00, txn = 8'h00;
    logic [7:0] host_addr, host_data_i, host_data_o, ctl_tx_byte, q;
    logic [7:0] ra[6] = '{8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h01};
    logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
    logic [7:0] sa[4] = '{8'h05, 8'h05, 8'h05, 8'h08}, sv[4] = '{8'h40, 8'h80, 8'h20, 8'h80};
    hpi_queue_t outlet_queue = HPI_Q_CTL;
    wire bus_write_clock, bus_frame_pulse, hdr_check_stb, cell_check_stb;
    wire ctl_tx_nack_stb, ctl_tx_ack_stb;
    int err_count = 0, total_checks = 0;
    // ======
    // Clocks and hookup
    initial forever #12.5 clk_sys = ~clk_sys;
    initial #7 forever #100 bus_read_clock = ~bus_read_clock;
    assign #2 bus_write_clock = bus_read_clock;
    always @(posedge bus_read_clock) fcnt <= fcnt + 4'h1;
    assign bus_frame_pulse = fcnt == 4'h0;
    assign {hdr_check_stb, cell_check_stb, ctl_tx_nack_stb, ctl_tx_ack_stb} = stb;
    hpi_host_model host (.clk(clk_sys), .rdy(host_ready_o), .din(host_data_o), .sel_n(host_sel_n),
        .rd_n(host_rd_n), .wr_n(host_wr_n), .addr(host_addr), .dout(host_data_i));
    hpi_port hpi_port_inst (.*);
    task automatic chk(input logic [7:0] id, seen, exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED item %h exp %h seen %h", id, exp, seen);
        end
    endtask
    task automatic rc(input logic [7:0] a, exp);
        host.acc(1'b0, a, 8'h00, q);
        chk(a, q, exp);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_sys) if (ctl_tx_valid && ctl_tx_ready) begin
        chk(txn, {ctl_tx_last, ctl_tx_byte[6:0]}, {txn == 8'd55, txn[6:0]});
        txn++;
    end
    always @(posedge clk_sys) ctl_tx_ready <= !ctl_tx_ready;
    initial begin
        #500us;
        err_count++;
        summarize;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        foreach (ra[i]) rc(ra[i], rv[i]);
        host.acc(1'b1, 8'h06, 8'hc0, q);
        host.acc(1'b1, 8'h09, 8'hff, q);
        for (int i = 0; i < 56; i++) host.acc(1'b1, 8'(8'ha0 + i), 8'(i), q);
        host.acc(1'b1, 8'h0a, 8'h42, q);
        for (int n = 0; n < 300 && txn < 8'd56; n++) @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
        chk(8'hd7, {7'h00, host_irq_o}, 8'h01);
        rc(8'h08, 8'h08);
        rc(8'h0a, 8'h40);
        chk(8'hd7, {7'h00, host_irq_o}, 8'h00);
        for (int b = 0; b < 4; b++) begin
            stb <= 4'(1 << b);
            @(posedge clk_sys);
            stb <= 4'h0;
            repeat (4) @(posedge clk_sys);
            chk(8'(b), {7'h00, host_irq_o}, {7'h00, b != 2});
            rc(sa[b], sv[b]);
            rc(sa[b], 8'h00);
        end
        for (int k = 0; k < 5; k++) for (int j = 0; j < 52; j++) begin
            {ctl_rx_valid, ctl_rx_last, ctl_rx_byte} <= {1'b1, j == 51, 8'(k * 64 + j)};
            @(posedge clk_sys);
        end
        {ctl_rx_valid, ctl_rx_last} <= 2'h0;
        repeat (3) @(posedge clk_sys);
        rc(8'h08, 8'h60);
        for (int k = 0; k < 4; k++) begin
            rc(8'h60, 8'(k * 64));
            rc(8'h93, 8'(k * 64 + 51));
            host.acc(1'b1, 8'h0a, 8'h41, q);
        end
        rc(8'h08, 8'h00);
        rc(8'h0a, 8'h40);
        summarize;
    end
endmodule
bind hpi_port hpi_port_properties hpi_port_properties_inst (.*);
`default_nettype wire
